// ---- pkg/ibpf_pkg.sv ----
// constants, types and the behaviour summary of the inertial burst packet framer
// What this block does
// - A 32-bit UART burst or auto packet opens with byte 0x80, ends with 0x0d and is 38 bytes long.
// - In 32-bit UART output the flag bytes are followed by temperature, x/y/z rate and x/y/z accel, each upper word then lower word, high byte first.
// - Content select 0xf007 with width select 0x7000 adds the lower words, giving the 32-bit layout.
// - The second byte holds new-sample flags for temperature, rate x/y/z, accel x/y/z and the range-exceeded flag in bit 0.
// - The third byte holds angle and velocity increment flags in bits 7..2, zero in bit 1 and the any-error flag in bit 0.
// - After the values come the pin word (levels high, directions low, pin 2 in bit 1), the sample counter and the checksum, high byte first.
// - A 16-bit SPI burst is 11 words with no header or delimiter, flags first and checksum last.
// - Content select 0xf007 with width select 0x0000 sends only the upper word of each value.
// - A 32-bit SPI burst is 18 words, each value as upper then lower word between flags and the tail words.
// - In UART auto mode a packet goes out on each output-rate tick that arrives while no packet is in progress and the selects are valid, without any host request.
package ibpf_pkg;

  // ****************************************
  // codes and selector values
  // ****************************************
  localparam logic [7:0] IBPF_HDR_CODE = 8'h80;
  localparam logic [7:0] IBPF_DELIM_CODE = 8'h0d;
  localparam logic [7:0] IBPF_BURST_CMD_CODE = 8'h00;
  localparam logic [15:0] IBPF_CONTENT_STD = 16'hf007;
  localparam logic [15:0] IBPF_WIDTH_WIDE = 16'h7000;
  localparam logic [15:0] IBPF_WIDTH_NARROW = 16'h0000;

  // ****************************************
  // snapshot word layout and packet lengths
  // ****************************************
  localparam int IBPF_NUM_WORDS = 18;
  localparam logic [4:0] IBPF_IDX_FLAG = 5'h00;
  localparam logic [4:0] IBPF_IDX_FIRST_VAL = 5'h01;
  localparam logic [4:0] IBPF_IDX_LAST_VAL = 5'h0e;
  localparam logic [4:0] IBPF_IDX_LAST = 5'h11;
  localparam logic [5:0] IBPF_UART_WIDE_UNITS = 6'h26;
  localparam logic [5:0] IBPF_UART_NARROW_UNITS = 6'h18;
  localparam logic [5:0] IBPF_SPI_WIDE_UNITS = 6'h12;
  localparam logic [5:0] IBPF_SPI_NARROW_UNITS = 6'h0b;
  localparam int IBPF_FLAG_UNUSED_BIT = 1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {IBPF_SPI_BURST, IBPF_UART_BURST, IBPF_UART_AUTO} ibpf_mode_t;
  typedef logic [4:0] ibpf_idx_t;
  typedef logic [IBPF_NUM_WORDS-1:0][15:0] ibpf_words_t;

  // one sample set; axis arrays run x, y, z
  typedef struct packed {
    logic nd_temp;
    logic [0:2] nd_rate;
    logic [0:2] nd_accel;
    logic range_exceeded_flag;
    logic [0:2] angle_increment_nd;
    logic [0:2] velocity_increment_nd;
    logic any_error_flag;
    logic [15:0] temp_upper_word;
    logic [15:0] temp_lower_word;
    logic [0:2][15:0] rate_upper_word;
    logic [0:2][15:0] rate_lower_word;
    logic [0:2][15:0] accel_upper_word;
    logic [0:2][15:0] accel_lower_word;
    logic pin1_level;
    logic pin2_level;
    logic pin1_direction;
    logic pin2_direction;
    logic [15:0] sample_count;
    logic [15:0] checksum;
  } ibpf_sample_t;

endpackage : ibpf_pkg

// ---- rtl/ibpf_snap_mem.sv ----
// snapshot memory holding one packet's words, registered read port
`timescale 1ns/100ps
module ibpf_snap_mem (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // parallel load of a whole snapshot
  input wire logic load_in,
  input wire ibpf_pkg::ibpf_words_t words_in,
  // read port
  input wire ibpf_pkg::ibpf_idx_t rd_idx_in,
  output logic [15:0] rd_data_out
);
  import ibpf_pkg::*;

  logic [15:0] mem_reg [IBPF_NUM_WORDS];

  // whole snapshot taken at once so a packet never mixes two samples
  always_ff @(posedge clk_in) begin
    if (load_in) begin
      for (int i = 0; i < IBPF_NUM_WORDS; i++) begin
        mem_reg[i] <= words_in[i];
      end
    end
  end

  // read data from a register, one cycle after the index
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_data_out <= 16'h0000;
    end else begin
      rd_data_out <= mem_reg[rd_idx_in];
    end
  end

endmodule : ibpf_snap_mem

// ---- rtl/ibpf_framer.sv ----
// burst packet framer: uart byte stream and spi word stream
`timescale 1ns/100ps
module ibpf_framer (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // configuration
  input wire ibpf_pkg::ibpf_mode_t MODE_IN,
  input wire logic [15:0] CONTENT_SELECT_IN,
  input wire logic [15:0] WIDTH_SELECT_IN,
  // requests and sample data
  input wire logic BURST_WRITE_IN,
  input wire logic [7:0] BURST_CMD_IN,
  input wire logic SAMPLE_TICK_IN,
  input wire ibpf_pkg::ibpf_sample_t SAMPLE_IN,
  // output stream
  input wire logic READY_IN,
  output logic [15:0] DATA_OUT,
  output logic VALID_OUT,
  output logic LAST_OUT,
  // status
  output logic BUSY_OUT,
  output logic CFG_BAD_OUT
);
  import ibpf_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_READ, ST_HI, ST_LO, ST_DELIM} ibpf_state_t;

  ibpf_state_t state_reg;
  ibpf_idx_t idx_reg;
  logic uart_reg;
  logic wide_reg;
  logic [15:0] rd_data;
  logic cfg_ok;
  logic trigger;
  logic start;
  logic slot_free;
  logic at_last;
  logic load_out;
  logic [15:0] data_next;
  logic last_next;

  // ****************************************
  // helpers
  // ****************************************
  // snapshot in full 32-bit order; the narrow packet skips the lower words
  function automatic ibpf_words_t pack_words(input ibpf_sample_t s);
    ibpf_words_t w;
    w[0] = {s.nd_temp, s.nd_rate, s.nd_accel, s.range_exceeded_flag,
            s.angle_increment_nd, s.velocity_increment_nd, 1'b0, s.any_error_flag};
    w[1] = s.temp_upper_word;
    w[2] = s.temp_lower_word;
    for (int a = 0; a < 3; a++) begin
      w[3 + 2*a] = s.rate_upper_word[a];
      w[4 + 2*a] = s.rate_lower_word[a];
      w[9 + 2*a] = s.accel_upper_word[a];
      w[10 + 2*a] = s.accel_lower_word[a];
    end
    w[15] = {6'h00, s.pin2_level, s.pin1_level, 6'h00, s.pin2_direction, s.pin1_direction};
    w[16] = s.sample_count;
    w[17] = s.checksum;
    return w;
  endfunction : pack_words

  // next word index; narrow mode steps over each lower word
  function automatic ibpf_idx_t next_idx(input ibpf_idx_t i, input logic wide);
    if (!wide && i >= IBPF_IDX_FIRST_VAL && i < IBPF_IDX_LAST_VAL) begin
      return ibpf_idx_t'(i + 5'h02);
    end
    return ibpf_idx_t'(i + 5'h01);
  endfunction : next_idx

  // ****************************************
  // request decode
  // ****************************************
  // only the two documented layouts are framed; anything else refuses requests
  assign cfg_ok = (CONTENT_SELECT_IN == IBPF_CONTENT_STD) &&
                  (WIDTH_SELECT_IN == IBPF_WIDTH_WIDE || WIDTH_SELECT_IN == IBPF_WIDTH_NARROW);
  assign trigger = (MODE_IN == IBPF_UART_AUTO) ? SAMPLE_TICK_IN :
                   (BURST_WRITE_IN && BURST_CMD_IN == IBPF_BURST_CMD_CODE);
  assign start = (state_reg == ST_IDLE) && trigger && cfg_ok;
  assign slot_free = !VALID_OUT || READY_IN;
  assign at_last = (idx_reg == IBPF_IDX_LAST);

  ibpf_snap_mem u_mem (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .load_in(start),
    .words_in(pack_words(SAMPLE_IN)),
    .rd_idx_in(idx_reg),
    .rd_data_out(rd_data)
  );

  // ****************************************
  // sequencing
  // ****************************************
  // packet sequence; uart adds header and delimiter around the words
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (start) state_reg <= (MODE_IN == IBPF_SPI_BURST) ? ST_READ : ST_HDR;
        ST_HDR: if (slot_free) state_reg <= ST_READ;
        ST_READ: state_reg <= ST_HI;
        ST_HI: begin
          if (slot_free) begin
            if (uart_reg) state_reg <= ST_LO;
            else state_reg <= at_last ? ST_IDLE : ST_READ;
          end
        end
        ST_LO: if (slot_free) state_reg <= at_last ? ST_DELIM : ST_READ;
        ST_DELIM: if (slot_free) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // mode and width latched per packet so mid-packet changes cannot tear it
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      uart_reg <= 1'b0;
      wide_reg <= 1'b0;
    end else if (start) begin
      uart_reg <= (MODE_IN != IBPF_SPI_BURST);
      wide_reg <= (WIDTH_SELECT_IN == IBPF_WIDTH_WIDE);
    end
  end

  // word index walk
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      idx_reg <= IBPF_IDX_FLAG;
    end else if (start) begin
      idx_reg <= IBPF_IDX_FLAG;
    end else if (slot_free && !at_last &&
                 ((state_reg == ST_HI && !uart_reg) || state_reg == ST_LO)) begin
      idx_reg <= next_idx(idx_reg, wide_reg);
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  // next unit on the stream; bytes sit in the low half
  always_comb begin
    load_out = slot_free;
    data_next = 16'h0000;
    last_next = 1'b0;
    case (state_reg)
      ST_HDR: data_next = {8'h00, IBPF_HDR_CODE};
      ST_HI: begin
        data_next = uart_reg ? {8'h00, rd_data[15:8]} : rd_data;
        last_next = !uart_reg && at_last;
      end
      ST_LO: data_next = {8'h00, rd_data[7:0]};
      ST_DELIM: begin
        data_next = {8'h00, IBPF_DELIM_CODE};
        last_next = 1'b1;
      end
      default: load_out = 1'b0;
    endcase
  end

  // output holds steady until taken
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      DATA_OUT <= 16'h0000;
      VALID_OUT <= 1'b0;
      LAST_OUT <= 1'b0;
    end else if (load_out) begin
      DATA_OUT <= data_next;
      VALID_OUT <= 1'b1;
      LAST_OUT <= last_next;
    end else if (READY_IN) begin
      VALID_OUT <= 1'b0;
      LAST_OUT <= 1'b0;
    end
  end

  // busy from accepted request until the last unit is queued
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      BUSY_OUT <= 1'b0;
    end else if (start) begin
      BUSY_OUT <= 1'b1;
    end else if (load_out && last_next) begin
      BUSY_OUT <= 1'b0;
    end
  end

  // configuration health
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      CFG_BAD_OUT <= 1'b0;
    end else begin
      CFG_BAD_OUT <= !cfg_ok;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [5:0] unit_cnt;
  logic take;
  assign take = VALID_OUT && READY_IN;

  // units handed over in the current packet
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      unit_cnt <= 6'h00;
    end else if (take) begin
      unit_cnt <= LAST_OUT ? 6'h00 : unit_cnt + 6'h01;
    end
  end

  sequence s_last_take;
    take && LAST_OUT;
  endsequence

  a_uart_header_first: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    VALID_OUT && uart_reg && unit_cnt == 6'h00 |-> DATA_OUT == {8'h00, IBPF_HDR_CODE})
    else $error("uart packet does not open with header");
  a_uart_delim_last: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_last_take and uart_reg |-> DATA_OUT == {8'h00, IBPF_DELIM_CODE})
    else $error("uart packet does not end with delimiter");
  a_uart_wide_len: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_last_take and (uart_reg && wide_reg) |-> unit_cnt == IBPF_UART_WIDE_UNITS - 6'h01)
    else $error("wide uart packet length wrong");
  a_uart_narrow_len: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_last_take and (uart_reg && !wide_reg) |-> unit_cnt == IBPF_UART_NARROW_UNITS - 6'h01)
    else $error("narrow uart packet length wrong");
  a_spi_narrow_len: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_last_take and (!uart_reg && !wide_reg) |-> unit_cnt == IBPF_SPI_NARROW_UNITS - 6'h01)
    else $error("narrow spi burst length wrong");
  a_spi_wide_len: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_last_take and (!uart_reg && wide_reg) |-> unit_cnt == IBPF_SPI_WIDE_UNITS - 6'h01)
    else $error("wide spi burst length wrong");
  a_flag_spare_zero: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    VALID_OUT && !uart_reg && unit_cnt == 6'h00 |-> !DATA_OUT[IBPF_FLAG_UNUSED_BIT])
    else $error("unused flag bit set");
  a_auto_needs_tick: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    $rose(BUSY_OUT) && MODE_IN == IBPF_UART_AUTO |-> $past(SAMPLE_TICK_IN))
    else $error("auto packet started without tick");
  a_request_starts: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    state_reg == ST_IDLE && cfg_ok && MODE_IN == IBPF_SPI_BURST && BURST_WRITE_IN &&
    BURST_CMD_IN == IBPF_BURST_CMD_CODE |=> BUSY_OUT ##[1:4] VALID_OUT)
    else $error("burst request not answered");
  a_output_holds: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    VALID_OUT && !READY_IN |=> VALID_OUT && $stable(DATA_OUT) && $stable(LAST_OUT))
    else $error("stalled output changed");

endmodule : ibpf_framer

// ---- testbench/ibpf_host_model.sv ----
// host-side sink model for the framer output stream
`timescale 1ns/100ps
module ibpf_host_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pacing control
  input wire logic slow_in,
  // stream from the framer
  input wire logic valid_in,
  input wire logic last_in,
  output logic ready_out,
  output logic [5:0] len_out
);
  logic [1:0] pace_reg;
  logic [5:0] cnt_reg;

  // free-running pace counter for the stall pattern
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pace_reg <= 2'h0;
    end else begin
      pace_reg <= pace_reg + 2'h1;
    end
  end

  // ready one cycle in four when slow, so the framer must hold its output
  always_comb ready_out = !slow_in || (pace_reg == 2'h3);

  // units per packet up to the last one; bench checks it against the layout
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= 6'h00;
      len_out <= 6'h00;
    end else if (valid_in && ready_out) begin
      if (last_in) begin
        len_out <= cnt_reg + 6'h01;
        cnt_reg <= 6'h00;
      end else begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end
endmodule : ibpf_host_model

// ---- testbench/testbench.sv ----
// self-checking testbench for the burst packet framer
`timescale 1ns/100ps
module testbench;
  import ibpf_pkg::*;
  logic REF_CLK_IN = 1'b0;
  logic RST_IN = 1'b1;
  ibpf_mode_t mode = IBPF_SPI_BURST;
  logic [15:0] width_sel = 16'h7000;
  logic [15:0] content_sel = 16'hf007;
  logic burst_wr = 1'b0;
  logic [7:0] burst_cmd = 8'h00;
  logic tick = 1'b0;
  logic slow = 1'b0;
  ibpf_sample_t smp = '0;
  logic ready, valid, last, busy, cfg_bad;
  logic [15:0] data;
  logic [5:0] host_len;
  logic [15:0] got[$];
  logic [15:0] exp[$];
  int done_cnt = 0;
  int error_cnt = 0;
  int n_compared = 0;

  ibpf_framer dut_u (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .MODE_IN(mode),
    .CONTENT_SELECT_IN(content_sel), .WIDTH_SELECT_IN(width_sel), .BURST_WRITE_IN(burst_wr),
    .BURST_CMD_IN(burst_cmd), .SAMPLE_TICK_IN(tick), .SAMPLE_IN(smp), .READY_IN(ready),
    .DATA_OUT(data), .VALID_OUT(valid), .LAST_OUT(last), .BUSY_OUT(busy),
    .CFG_BAD_OUT(cfg_bad));
  ibpf_host_model host_u (.clk_in(REF_CLK_IN), .rst_in(RST_IN), .slow_in(slow),
    .valid_in(valid), .last_in(last), .ready_out(ready), .len_out(host_len));

  initial forever #10 REF_CLK_IN = ~REF_CLK_IN;

  // capture every accepted unit; sampled at the edge, before updates land
  always @(posedge REF_CLK_IN) begin
    if (valid && ready) begin
      got.push_back(data);
      if (last) done_cnt++;
    end
  end

  // ****************************************
  // compare, expectation and access tasks
  // ****************************************
  task automatic cmp(input logic [15:0] act, input logic [15:0] expv);
    n_compared++;
    if (act !== expv) begin
      error_cnt++;
      $display("MISMATCH t=%0t act=%h exp=%h", $time, act, expv);
    end
  endtask : cmp

  // word list from the sample, then for uart split into bytes with header and delimiter
  task automatic build(input bit uart, input bit wide);
    logic [15:0] w[$];
    w = {};
    exp = {};
    w.push_back({smp.nd_temp, smp.nd_rate, smp.nd_accel, smp.range_exceeded_flag,
      smp.angle_increment_nd, smp.velocity_increment_nd, 1'b0, smp.any_error_flag});
    w.push_back(smp.temp_upper_word);
    if (wide) w.push_back(smp.temp_lower_word);
    for (int i = 0; i < 3; i++) begin
      w.push_back(smp.rate_upper_word[i]);
      if (wide) w.push_back(smp.rate_lower_word[i]);
    end
    for (int i = 0; i < 3; i++) begin
      w.push_back(smp.accel_upper_word[i]);
      if (wide) w.push_back(smp.accel_lower_word[i]);
    end
    w.push_back({6'h00, smp.pin2_level, smp.pin1_level, 6'h00, smp.pin2_direction,
      smp.pin1_direction});
    w.push_back(smp.sample_count);
    w.push_back(smp.checksum);
    if (!uart) begin
      exp = w;
    end else begin
      exp.push_back(16'h0080);
      foreach (w[i]) begin
        exp.push_back({8'h00, w[i][15:8]});
        exp.push_back({8'h00, w[i][7:0]});
      end
      exp.push_back(16'h000d);
    end
  endtask : build

  // configure, request one packet, collect it and compare unit by unit
  task automatic run_case(input ibpf_mode_t m, input logic [15:0] wsel, input bit slw,
      input int n_units);
    int start;
    build(m != IBPF_SPI_BURST, wsel == 16'h7000);
    got = {};
    start = done_cnt;
    @(posedge REF_CLK_IN);
    mode <= m;
    width_sel <= wsel;
    slow <= slw;
    @(posedge REF_CLK_IN);
    if (m == IBPF_UART_AUTO) tick <= 1'b1;
    else burst_wr <= 1'b1;
    @(posedge REF_CLK_IN);
    tick <= 1'b0;
    burst_wr <= 1'b0;
    for (int k = 0; k < 600 && done_cnt == start; k++) @(posedge REF_CLK_IN);
    @(posedge REF_CLK_IN);
    // a packet that never ends within the wait limit counts as a mismatch here
    cmp(16'(done_cnt - start), 16'h0001);
    cmp(16'(got.size()), 16'(n_units));
    cmp({10'h000, host_len}, 16'(n_units));
    foreach (exp[i]) cmp((i < got.size()) ? got[i] : 16'hxxxx, exp[i]);
    $display("test done: mode %0d width %h units %0d", m, wsel, got.size());
  endtask : run_case

  // a request that must be ignored: busy stays low
  task automatic refused(input ibpf_mode_t m, input bit wr, input bit tk,
      input logic [7:0] cmd);
    @(posedge REF_CLK_IN);
    mode <= m;
    @(posedge REF_CLK_IN);
    burst_wr <= wr;
    tick <= tk;
    burst_cmd <= cmd;
    @(posedge REF_CLK_IN);
    burst_wr <= 1'b0;
    tick <= 1'b0;
    burst_cmd <= 8'h00;
    repeat (3) @(posedge REF_CLK_IN);
    cmp({15'h0000, busy}, 16'h0000);
    $display("test done: refused request mode %0d", m);
  endtask : refused

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    smp.nd_temp = 1'b1;
    smp.nd_rate = 3'b101;
    smp.nd_accel = 3'b010;
    smp.range_exceeded_flag = 1'b1;
    smp.angle_increment_nd = 3'b110;
    smp.velocity_increment_nd = 3'b011;
    smp.any_error_flag = 1'b1;
    smp.temp_upper_word = 16'ha1b2;
    smp.temp_lower_word = 16'hc3d4;
    for (int i = 0; i < 3; i++) begin
      smp.rate_upper_word[i] = 16'h1100 + 16'(i);
      smp.rate_lower_word[i] = 16'h2200 + 16'(i);
      smp.accel_upper_word[i] = 16'h3300 + 16'(i);
      smp.accel_lower_word[i] = 16'h4400 + 16'(i);
    end
    smp.pin1_level = 1'b1;
    smp.pin2_direction = 1'b1;
    smp.sample_count = 16'h0e5f;
    smp.checksum = 16'h7a69;
    repeat (4) @(posedge REF_CLK_IN);
    RST_IN <= 1'b0;
    run_case(IBPF_UART_BURST, 16'h7000, 1'b0, 38);
    run_case(IBPF_UART_BURST, 16'h0000, 1'b1, 24);
    run_case(IBPF_SPI_BURST, 16'h0000, 1'b0, 11);
    run_case(IBPF_SPI_BURST, 16'h7000, 1'b1, 18);
    run_case(IBPF_UART_AUTO, 16'h7000, 1'b1, 38);
    refused(IBPF_UART_AUTO, 1'b1, 1'b0, 8'h00);
    refused(IBPF_SPI_BURST, 1'b1, 1'b0, 8'h01);
    refused(IBPF_SPI_BURST, 1'b0, 1'b1, 8'h00);
    @(posedge REF_CLK_IN);
    width_sel <= 16'h1234;
    repeat (3) @(posedge REF_CLK_IN);
    cmp({15'h0000, cfg_bad}, 16'h0001);
    refused(IBPF_SPI_BURST, 1'b1, 1'b0, 8'h00);
    // wrong content select with a good width must refuse as well
    @(posedge REF_CLK_IN);
    width_sel <= 16'h7000;
    content_sel <= 16'hf006;
    repeat (3) @(posedge REF_CLK_IN);
    cmp({15'h0000, cfg_bad}, 16'h0001);
    refused(IBPF_SPI_BURST, 1'b1, 1'b0, 8'h00);
    @(posedge REF_CLK_IN);
    content_sel <= 16'hf007;
    repeat (3) @(posedge REF_CLK_IN);
    cmp({15'h0000, cfg_bad}, 16'h0000);
    // reset in the middle of a stalled packet must clear the stream
    @(posedge REF_CLK_IN);
    burst_wr <= 1'b1;
    @(posedge REF_CLK_IN);
    burst_wr <= 1'b0;
    repeat (4) @(posedge REF_CLK_IN);
    RST_IN <= 1'b1;
    repeat (2) @(posedge REF_CLK_IN);
    RST_IN <= 1'b0;
    @(posedge REF_CLK_IN);
    cmp({14'h0000, busy, valid}, 16'h0000);
    $display("test done: reset during packet");
    run_case(IBPF_SPI_BURST, 16'h7000, 1'b0, 18);
    conclude();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(20 * 20000);
    error_cnt++;
    $display("timeout at t=%0t", $time);
    conclude();
  end
endmodule : testbench
